//--- verilog/dual_timer_mode_control.sv
/*
 * Mode control for two 8-bit timers behind an AXI4-Lite slave, with the
 * timer input pin synchronised and the timer output pin registered.
 * Assumes one clock, a synchronous reset and an asynchronous input pin.
 */
`default_nettype none
`include "timer_defs.svh"

// Notes on behaviour
// - Bits 7:6 route the timer output pin.
// - Bits 5:4 choose the input pin role.
// - Bit 3 enables counting of timer one.
// - Writing one to bit 2 loads timer one.
// - Bit 1 enables counting of timer zero.
// - Writing one to bit 0 loads timer zero.
// - Timer one register: writes set the start value, reads return the count.
module dual_timer_mode_control
   import timer_pkg::*;
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic timer_input_pin_in,
   output logic timer_output_pin_out,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [`ADDR_W-1:0] s_axi_awaddr_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   input wire logic [`DATA_W-1:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   output logic [1:0] s_axi_bresp_out,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   input wire logic [`ADDR_W-1:0] s_axi_araddr_in,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic [`DATA_W-1:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out
);

   ctrl_state_t st_q;
   ctrl_state_t st_d;

   logic pin_rise;
   logic retrig;
   logic tick_one;
   logic tick_zero;
   logic load_one_any;
   logic [`TIMER_W-1:0] count_one;
   logic [`TIMER_W-1:0] count_zero;
   logic toggle_one;
   logic toggle_zero;
   logic last_one;
   logic last_zero;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------

   function automatic logic hit(input logic [`ADDR_W-3:0] idx,
                                input logic [7:0] reg_idx);
      hit = idx == (`ADDR_W-2)'(reg_idx);
   endfunction

   function automatic logic one_source(input in_mode_t m,
                                       input logic rise,
                                       input logic level,
                                       input logic run);
      case (m)
         IN_CLOCK: begin
            one_source = rise;
         end
         IN_GATE: begin
            one_source = level;
         end
         default: begin
            one_source = run;
         end
      endcase
   endfunction

   // ----------------------------------------------------------------------
   // Timer sources
   // ----------------------------------------------------------------------

   assign pin_rise = st_q.pin_sync & ~st_q.pin_prev;
   assign retrig = st_q.mode.count_one && pin_rise &&
                   (st_q.mode.in_mode == IN_TRIG_AGAIN);
   assign tick_one = st_q.mode.count_one && one_source(st_q.mode.in_mode,
                     pin_rise, st_q.pin_sync, st_q.run_one);
   assign tick_zero = st_q.mode.count_zero;
   assign load_one_any = st_q.load_one | retrig;

   timer_counter_unit #(
      .WIDTH(`TIMER_W)
   ) u_one (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .load_in(load_one_any),
      .tick_in(tick_one),
      .start_in(st_q.start_one),
      .count_out(count_one),
      .toggle_out(toggle_one),
      .last_out(last_one)
   );

   timer_counter_unit #(
      .WIDTH(`TIMER_W)
   ) u_zero (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .load_in(st_q.load_zero),
      .tick_in(tick_zero),
      .start_in(st_q.start_zero),
      .count_out(count_zero),
      .toggle_out(toggle_zero),
      .last_out(last_zero)
   );

   // ----------------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------------

   always_comb begin
      logic [`DATA_W-1:0] rd;
      logic mapped;
      rd = '0;
      mapped = 1'b0;
      st_d = st_q;
      st_d.load_one = 1'b0;
      st_d.load_zero = 1'b0;
      st_d.pin_meta = timer_input_pin_in;
      st_d.pin_sync = st_q.pin_meta;
      st_d.pin_prev = st_q.pin_sync;
      st_d.clk_div = ~st_q.clk_div;

      // A trigger counts one span; only the retriggerable mode restarts it.
      if (!st_q.mode.count_one || !st_q.mode.in_mode[1]) begin
         st_d.run_one = 1'b0;
      end else begin
         if (tick_one && last_one) begin
            st_d.run_one = 1'b0;
         end
         if (pin_rise && (st_q.mode.in_mode[0] || !st_q.run_one)) begin
            st_d.run_one = 1'b1;
         end
      end

      case (st_q.mode.out_mode)
         OUT_OFF: begin
            st_d.pin_out = 1'b0;
         end
         OUT_ZERO: begin
            st_d.pin_out = toggle_zero;
         end
         OUT_ONE: begin
            st_d.pin_out = toggle_one;
         end
         OUT_CLOCK: begin
            st_d.pin_out = st_q.clk_div;
         end
         default: begin
            st_d.pin_out = 1'b0;
         end
      endcase

      if (s_axi_awvalid_in && st_q.awready) begin
         st_d.aw_have = 1'b1;
         st_d.aw_idx = s_axi_awaddr_in[`ADDR_W-1:2];
      end
      if (s_axi_wvalid_in && st_q.wready) begin
         st_d.w_have = 1'b1;
         st_d.w_data = s_axi_wdata_in[`TIMER_W-1:0];
         st_d.w_lane0 = s_axi_wstrb_in[0];
      end

      case (st_q.wr)
         WR_IDLE: begin
            if (st_q.aw_have && st_q.w_have) begin
               st_d.wr = WR_RESP;
               st_d.aw_have = 1'b0;
               st_d.w_have = 1'b0;
               st_d.bresp = `RESP_OKAY;
               if (hit(st_q.aw_idx, `MODE_IDX)) begin
                  if (st_q.w_lane0) begin
                     st_d.mode.out_mode = out_mode_t'(
                        st_q.w_data[`OUT_MODE_HI:`OUT_MODE_LO]);
                     st_d.mode.in_mode = in_mode_t'(
                        st_q.w_data[`IN_MODE_HI:`IN_MODE_LO]);
                     st_d.mode.count_one =
                        st_q.w_data[`COUNT_ONE_BIT];
                     st_d.load_one = st_q.w_data[`LOAD_ONE_BIT];
                     st_d.mode.count_zero =
                        st_q.w_data[`COUNT_ZERO_BIT];
                     st_d.load_zero = st_q.w_data[`LOAD_ZERO_BIT];
                  end
               end else if (hit(st_q.aw_idx, `ONE_IDX)) begin
                  if (st_q.w_lane0) begin
                     st_d.start_one = st_q.w_data;
                  end
               end else if (hit(st_q.aw_idx, `ZERO_START_IDX)) begin
                  if (st_q.w_lane0) begin
                     st_d.start_zero = st_q.w_data;
                  end
               end else if (!hit(st_q.aw_idx, `ZERO_COUNT_IDX)) begin
                  st_d.bresp = `RESP_DECERR;
               end
            end
         end
         WR_RESP: begin
            if (s_axi_bready_in) begin
               st_d.wr = WR_IDLE;
            end
         end
         default: begin
            st_d.wr = WR_IDLE;
         end
      endcase
      st_d.awready = (st_d.wr == WR_IDLE) && !st_d.aw_have;
      st_d.wready = (st_d.wr == WR_IDLE) && !st_d.w_have;
      st_d.bvalid = st_d.wr == WR_RESP;

      // Load bits always read as zero; their effect is the one-cycle pulse.
      if (hit(s_axi_araddr_in[`ADDR_W-1:2], `MODE_IDX)) begin
         rd[7:0] = {st_q.mode.out_mode, st_q.mode.in_mode,
                    st_q.mode.count_one, 1'b0, st_q.mode.count_zero, 1'b0};
         mapped = 1'b1;
      end else if (hit(s_axi_araddr_in[`ADDR_W-1:2], `ONE_IDX)) begin
         rd[7:0] = count_one;
         mapped = 1'b1;
      end else if (hit(s_axi_araddr_in[`ADDR_W-1:2], `ZERO_START_IDX)) begin
         rd[7:0] = st_q.start_zero;
         mapped = 1'b1;
      end else if (hit(s_axi_araddr_in[`ADDR_W-1:2], `ZERO_COUNT_IDX)) begin
         rd[7:0] = count_zero;
         mapped = 1'b1;
      end
      if (s_axi_arvalid_in && st_q.arready) begin
         st_d.rvalid = 1'b1;
         st_d.rdata = rd;
         st_d.rresp = mapped ? `RESP_OKAY : `RESP_DECERR;
      end else if (st_q.rvalid && s_axi_rready_in) begin
         st_d.rvalid = 1'b0;
      end
      st_d.arready = !st_d.rvalid;
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_q <= '0;
         st_q.wr <= WR_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------

   assign timer_output_pin_out = st_q.pin_out;
   assign s_axi_awready_out = st_q.awready;
   assign s_axi_wready_out = st_q.wready;
   assign s_axi_bvalid_out = st_q.bvalid;
   assign s_axi_bresp_out = st_q.bresp;
   assign s_axi_arready_out = st_q.arready;
   assign s_axi_rvalid_out = st_q.rvalid;
   assign s_axi_rdata_out = st_q.rdata;
   assign s_axi_rresp_out = st_q.rresp;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------

   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (reset_in);

   a_out_off_low: assert property (
      st_q.mode.out_mode == OUT_OFF |=> timer_output_pin_out == 1'b0)
      else $error("Output pin not low in off mode.");

   a_out_clock_toggle: assert property (
      st_q.mode.out_mode == OUT_CLOCK ##1 st_q.mode.out_mode == OUT_CLOCK
      |=> timer_output_pin_out != $past(timer_output_pin_out))
      else $error("Output pin not toggling in clock mode.");

   a_out_follows_one: assert property (
      st_q.mode.out_mode == OUT_ONE |=> timer_output_pin_out ==
      $past(toggle_one))
      else $error("Output pin does not follow timer one.");

   a_gate_low_hold: assert property (
      st_q.mode.in_mode == IN_GATE && !st_q.pin_sync && !st_q.load_one
      |=> $stable(count_one))
      else $error("Timer one counted with gate low.");

   a_one_stop_hold: assert property (
      !st_q.mode.count_one && !st_q.load_one |=> $stable(count_one))
      else $error("Timer one counted while disabled.");

   a_one_load_value: assert property (
      st_q.load_one |=> count_one == $past(st_q.start_one))
      else $error("Timer one not loaded with start value.");

   a_zero_stop_hold: assert property (
      !st_q.mode.count_zero && !st_q.load_zero |=> $stable(count_zero))
      else $error("Timer zero counted while disabled.");

   a_zero_load_value: assert property (
      st_q.load_zero |=> count_zero == $past(st_q.start_zero))
      else $error("Timer zero not loaded with start value.");

   a_one_read_back: assert property (
      s_axi_arvalid_in && st_q.arready &&
      hit(s_axi_araddr_in[`ADDR_W-1:2], `ONE_IDX)
      |=> s_axi_rvalid_out && s_axi_rdata_out[7:0] == $past(count_one))
      else $error("Timer one read returned wrong value.");

   a_load_self_clear: assert property (
      st_q.load_one || st_q.load_zero
      |=> !st_q.load_one && !st_q.load_zero ##1 !st_q.load_one)
      else $error("Load request did not clear itself.");

   c_one_wraps: cover property (tick_one && last_one);
   c_retrigger: cover property (retrig && st_q.run_one);
   c_clock_out: cover property (st_q.mode.out_mode == OUT_CLOCK [*3]);

endmodule

`default_nettype wire

//--- include/timer_defs.svh
/*
 * Offsets, field positions, reset values and widths of the dual timer
 * mode control block. Assumes inclusion by bare name from the include path.
 */
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

`define TIMER_W 8
`define DATA_W 32
`define ADDR_W 12

`define MODE_IDX 8'hF1
`define ONE_IDX 8'hF2
`define ZERO_START_IDX 8'hF3
`define ZERO_COUNT_IDX 8'hF4

`define OUT_MODE_HI 7
`define OUT_MODE_LO 6
`define IN_MODE_HI 5
`define IN_MODE_LO 4
`define COUNT_ONE_BIT 3
`define LOAD_ONE_BIT 2
`define COUNT_ZERO_BIT 1
`define LOAD_ZERO_BIT 0

`define MODE_RESET 8'h00
`define START_RESET 8'h00

`define RESP_OKAY 2'h0
`define RESP_DECERR 2'h3

`endif

//--- include/timer_pkg.sv
/*
 * Types shared by the dual timer mode control block.
 * Assumes timer_defs.svh is on the include path.
 */
`include "timer_defs.svh"

package timer_pkg;

   typedef enum logic [1:0] {
      OUT_OFF = 2'h0,
      OUT_ZERO = 2'h1,
      OUT_ONE = 2'h2,
      OUT_CLOCK = 2'h3
   } out_mode_t;

   typedef enum logic [1:0] {
      IN_CLOCK = 2'h0,
      IN_GATE = 2'h1,
      IN_TRIG_ONCE = 2'h2,
      IN_TRIG_AGAIN = 2'h3
   } in_mode_t;

   typedef enum logic [1:0] {
      WR_IDLE = 2'h1,
      WR_RESP = 2'h2
   } wr_state_t;

   typedef struct packed {
      out_mode_t out_mode;
      in_mode_t in_mode;
      logic count_one;
      logic count_zero;
   } mode_fields_t;

   typedef struct packed {
      mode_fields_t mode;
      logic load_one;
      logic load_zero;
      logic [`TIMER_W-1:0] start_one;
      logic [`TIMER_W-1:0] start_zero;
      logic pin_meta;
      logic pin_sync;
      logic pin_prev;
      logic run_one;
      logic clk_div;
      logic pin_out;
      wr_state_t wr;
      logic aw_have;
      logic w_have;
      logic [`ADDR_W-3:0] aw_idx;
      logic [`TIMER_W-1:0] w_data;
      logic w_lane0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [`DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } ctrl_state_t;

endpackage

//--- verilog/timer_counter_unit.sv
/*
 * One down-counting timer with start value, load and tick.
 * Assumes tick and load come from logic on the same clock.
 */
`default_nettype none

module timer_counter_unit #(
   parameter int WIDTH = 8
) (
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic load_in,
   input wire logic tick_in,
   input wire logic [WIDTH-1:0] start_in,
   output logic [WIDTH-1:0] count_out,
   output logic toggle_out,
   output logic last_out
);

   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic toggle;
   } unit_state_t;

   unit_state_t st_q;
   unit_state_t st_d;

   assign count_out = st_q.count;
   assign toggle_out = st_q.toggle;
   assign last_out = (st_q.count == '0) || (st_q.count == WIDTH'(1));

   // A load beats a tick in the same cycle, so a fresh start is never skewed.
   always_comb begin
      st_d = st_q;
      if (load_in) begin
         st_d.count = start_in;
      end else if (tick_in) begin
         if (last_out) begin
            st_d.count = start_in;
            st_d.toggle = ~st_q.toggle;
         end else begin
            st_d.count = WIDTH'(st_q.count - WIDTH'(1));
         end
      end
   end

   always_ff @(posedge clk_in) begin
      if (reset_in) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

endmodule

`default_nettype wire

//--- verif/timer_pin_partner.sv
/*
 * Far-side model: drives the timer input pin as a clock, gate or
 * trigger source, and loads the timer output pin, counting its rises.
 * Assumes the bench calls pulse from its main thread, after a clock edge.
 */
`default_nettype none

module timer_pin_partner (
   input wire logic clk_in,
   input wire logic load_pin_in,
   output logic pin_out,
   output logic [15:0] edges_out
);
   timeunit 1ns;
   timeprecision 1ns;

   logic last_q;

   initial begin
      pin_out = 1'b0;
      edges_out = 16'h0000;
      last_q = 1'b0;
   end

   // The load only counts rises, so the bench can judge activity.
   always @(posedge clk_in) begin
      last_q <= load_pin_in;
      if (load_pin_in === 1'b1 && last_q === 1'b0) begin
         edges_out <= edges_out + 16'h0001;
      end
   end

   // A long high time stands for a slow source, a short one a prompt one.
   task automatic pulse(input int n, input int high);
      repeat (n) begin
         @(posedge clk_in);
         pin_out <= 1'b1;
         repeat (high) @(posedge clk_in);
         pin_out <= 1'b0;
         repeat (4) @(posedge clk_in);
      end
   endtask
endmodule

`default_nettype wire

//--- verif/testbench.sv
/*
 * Self-checking bench for the dual timer mode control block.
 * Assumes the design, package and partner model are compiled first.
 */
`default_nettype none
`include "timer_defs.svh"

module testbench
   import timer_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk_in, reset_in, pin_in, pin_out;
   logic awvalid, awready, wvalid, wready, bvalid, bready;
   logic arvalid, arready, rvalid, rready;
   logic [`ADDR_W-1:0] awaddr, araddr;
   logic [`DATA_W-1:0] wdata, rdata;
   logic [3:0] wstrb;
   logic [1:0] bresp, rresp;
   logic [15:0] edges;
   int errors = 0;
   int n_compared = 0;

   dual_timer_mode_control u_dual_timer_mode_control (
      .clk_in(clk_in), .reset_in(reset_in),
      .timer_input_pin_in(pin_in), .timer_output_pin_out(pin_out),
      .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_awaddr_in(awaddr), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_wdata_in(wdata),
      .s_axi_wstrb_in(wstrb), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_bresp_out(bresp),
      .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
      .s_axi_araddr_in(araddr), .s_axi_rvalid_out(rvalid),
      .s_axi_rready_in(rready), .s_axi_rdata_out(rdata),
      .s_axi_rresp_out(rresp));

   timer_pin_partner u_timer_pin_partner (
      .clk_in(clk_in), .load_pin_in(pin_out),
      .pin_out(pin_in), .edges_out(edges));

   // ---------------------------------------------------------------
   // Bus tasks
   // ---------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // Each task starts one edge on, so no strobe is set twice at an edge.
   task automatic axi_wr(input logic [7:0] idx, input logic [7:0] val,
                         output logic [1:0] resp);
      logic aw_done;
      logic w_done;
      @(posedge clk_in);
      aw_done = 1'b0;
      w_done = 1'b0;
      awaddr <= {2'h0, idx, 2'h0};
      wdata <= {24'h000000, val};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge clk_in);
         if (awvalid && awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wvalid && wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge clk_in); while (bvalid !== 1'b1);
      resp = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d,
                         output logic [1:0] resp);
      @(posedge clk_in);
      araddr <= {2'h0, idx, 2'h0};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_in); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk_in); while (rvalid !== 1'b1);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task automatic t_fields();
      logic [31:0] d;
      logic [1:0] r;
      logic [7:0] v;
      axi_rd(`MODE_IDX, d, r);
      chk("mode_reset", d, 32'h00000000);
      for (int o = 0; o < 4; o++) begin
         for (int i = 0; i < 4; i++) begin
            v = {o[1:0], i[1:0], 4'hA};
            axi_wr(`MODE_IDX, v, r);
            axi_rd(`MODE_IDX, d, r);
            chk("mode_fields", d, {24'h000000, v});
         end
      end
   endtask

   task automatic t_loads();
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(`ONE_IDX, 8'h5A, r);
      chk("one_wr_resp", r, `RESP_OKAY);
      axi_wr(`MODE_IDX, 8'h00, r);
      axi_rd(`ONE_IDX, d, r);
      chk("one_no_load", d, 32'h00000000);
      axi_wr(`MODE_IDX, 8'h04, r);
      axi_rd(`ONE_IDX, d, r);
      chk("one_loaded", d, 32'h0000005A);
      axi_rd(`MODE_IDX, d, r);
      chk("load_cleared", d, 32'h00000000);
      axi_wr(`ONE_IDX, 8'h11, r);
      axi_wr(`MODE_IDX, 8'h00, r);
      axi_rd(`ONE_IDX, d, r);
      chk("one_kept", d, 32'h0000005A);
      axi_wr(`ZERO_START_IDX, 8'h33, r);
      axi_wr(`MODE_IDX, 8'h01, r);
      repeat (10) @(posedge clk_in);
      axi_rd(`ZERO_COUNT_IDX, d, r);
      chk("zero_held", d, 32'h00000033);
      axi_wr(`MODE_IDX, 8'h02, r);
      axi_rd(`ZERO_COUNT_IDX, d, r);
      chk("zero_runs", d, 32'h00000031);
   endtask

   // Timer one counts on the pin; the partner shapes each pin role.
   task automatic t_pin_roles();
      logic [31:0] d;
      logic [1:0] r;
      axi_wr(`ONE_IDX, 8'h10, r);
      axi_wr(`MODE_IDX, {OUT_OFF, IN_CLOCK, 4'hC}, r);
      u_timer_pin_partner.pulse(3, 4);
      axi_rd(`ONE_IDX, d, r);
      chk("ext_clock", d, 32'h0000000D);
      axi_wr(`MODE_IDX, 8'h00, r);
      u_timer_pin_partner.pulse(2, 2);
      axi_rd(`ONE_IDX, d, r);
      chk("one_stopped", d, 32'h0000000D);
      axi_wr(`ONE_IDX, 8'h20, r);
      axi_wr(`MODE_IDX, {OUT_OFF, IN_GATE, 4'hC}, r);
      u_timer_pin_partner.pulse(1, 10);
      axi_rd(`ONE_IDX, d, r);
      chk("gate", d, 32'h00000016);
      axi_wr(`ONE_IDX, 8'h40, r);
      axi_wr(`MODE_IDX, {OUT_OFF, IN_TRIG_ONCE, 4'hC}, r);
      u_timer_pin_partner.pulse(1, 2);
      axi_rd(`ONE_IDX, d, r);
      chk("trigger", d, 32'h0000003C);
      // A second edge restarts the span; a one-shot would show 31 here.
      axi_wr(`MODE_IDX, {OUT_OFF, IN_TRIG_AGAIN, 4'hC}, r);
      u_timer_pin_partner.pulse(2, 2);
      axi_rd(`ONE_IDX, d, r);
      chk("retrigger", d, 32'h0000003C);
   endtask

   task automatic t_out_pin();
      logic [1:0] r;
      logic a;
      logic [15:0] e;
      axi_wr(`MODE_IDX, 8'h00, r);
      repeat (4) @(posedge clk_in);
      chk("pin_off", pin_out, 1'b0);
      axi_wr(`MODE_IDX, {OUT_CLOCK, IN_CLOCK, 4'h0}, r);
      repeat (3) @(posedge clk_in);
      a = pin_out;
      @(posedge clk_in);
      chk("pin_clock", pin_out, {31'h00000000, ~a});
      axi_wr(`ZERO_START_IDX, 8'h04, r);
      axi_wr(`MODE_IDX, {OUT_ZERO, IN_CLOCK, 4'h3}, r);
      e = edges;
      repeat (40) @(posedge clk_in);
      chk("pin_zero", edges != e, 1);
      axi_wr(`ONE_IDX, 8'h02, r);
      axi_wr(`MODE_IDX, {OUT_ONE, IN_CLOCK, 4'hC}, r);
      e = edges;
      u_timer_pin_partner.pulse(8, 3);
      chk("pin_one", edges != e, 1);
   endtask

   task automatic t_unmapped();
      logic [31:0] d;
      logic [1:0] r;
      axi_rd(8'h00, d, r);
      chk("bad_rd_data", d, 32'h00000000);
      chk("bad_rd_resp", r, `RESP_DECERR);
      axi_wr(8'hF0, 8'hFF, r);
      chk("bad_wr_resp", r, `RESP_DECERR);
   endtask

   // ---------------------------------------------------------------
   // Run control
   // ---------------------------------------------------------------
   task automatic test_done();
      if (errors == 0 && n_compared > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      clk_in = 1'b0;
      forever #25 clk_in = ~clk_in;
   end

   // The whole run needs under 500 cycles; this allows 40000, over eighty times that.
   initial begin
      #2000000;
      errors++;
      test_done();
   end

   initial begin
      reset_in = 1'b1;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
      awaddr = '0;
      araddr = '0;
      wdata = '0;
      wstrb = 4'hF;
      repeat (16) @(posedge clk_in);
      reset_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      t_fields();
      t_loads();
      t_pin_roles();
      t_out_pin();
      t_unmapped();
      test_done();
   end
endmodule

`default_nettype wire
